// [design/buck_regs_pkg.sv]
package buck_regs_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] BUCK1_VOLTAGE_SELECT_OFS = 8'h00;
  localparam logic [7:0] BUCK2_VOLTAGE_SELECT_OFS = 8'h01;
  localparam logic [7:0] BUCK3_VOLTAGE_SELECT_OFS = 8'h02;
  localparam logic [7:0] BUCK1_COMMAND_OFS = 8'h03;
  localparam logic [7:0] BUCK2_COMMAND_OFS = 8'h04;
  localparam logic [7:0] BUCK3_COMMAND_OFS = 8'h05;
  localparam logic [7:0] SYSTEM_HEALTH_OFS = 8'h06;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] SELECT_RESET = 8'h00;
  localparam logic [7:0] COMMAND_RESET = 8'h00;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int GO_BIT = 7;
  localparam int DISABLE_BIT = 0;
  localparam int FORCED_PWM_BIT = 1;
  localparam int SLEW_LSB = 4;
  localparam int OVERTEMP_BIT = 7;
  localparam int OVERCURRENT_LSB = 4;
  localparam int WARNING_BIT = 3;
  localparam int POWER_OK_LSB = 0;
  // ****************************************
  // Voltage code scale, in millivolts
  // ****************************************
  localparam logic [10:0] VID_BASE_MV = 11'd680;
  localparam logic [3:0] VID_STEP_MV = 4'd10;
  // ****************************************
  // Serial byte timing, in SCL pulses
  // ****************************************
  localparam logic [3:0] DATA_PULSES = 4'd8;
  localparam logic [3:0] ACK_PULSE = 4'd9;
  // Serial protocol phases
  typedef enum logic [2:0] {
    PH_IDLE, PH_ADDR, PH_REG, PH_WRITE, PH_READ
  } phase_type;
endpackage

// [design/triple_buck_i2c_control_regs.sv]
`timescale 1ns/1ps
module triple_buck_i2c_control_regs
  import buck_regs_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = 7'h48
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [2:0] channel_enable_pin,
  input wire logic [2:0] fb_in_window,
  input wire logic [2:0] fb_out_window,
  input wire logic overtemp_hot,
  input wire logic overtemp_cool,
  input wire logic [2:0] overcurrent_hiccup,
  input wire logic overtemp_warning_flag,
  input wire logic switch_tick,
  output logic [2:0] channel_power_ok,
  output logic switching_halt,
  output logic sequence_restart,
  output logic [2:0] channel_run,
  output logic [2:0] forced_pwm,
  output logic [2:0] vid_go,
  output logic [20:0] applied_code,
  output logic [32:0] target_mv
);
  localparam int SYNC_W = 19;

  // ****************************************
  // Link domain: bit capture on SCL
  // ****************************************
  logic rx_bit; // Data bit taken at SCL rise
  logic rise_toggle; // Flips on every SCL rise
  logic next_rx_bit;
  logic next_rise_toggle;

  // Next values of the link capture
  always_comb begin
    next_rx_bit = sda_in;
    next_rise_toggle = ~rise_toggle;
  end

  // Link capture registers
  always_ff @(posedge scl or negedge arst_n) begin
    if (!arst_n) begin
      rx_bit <= 1'b0;
      rise_toggle <= 1'b0;
    end else begin
      rx_bit <= next_rx_bit;
      rise_toggle <= next_rise_toggle;
    end
  end

  // ****************************************
  // Synchronisers into the clock domain
  // ****************************************
  logic [SYNC_W-1:0] sync_a; // First stage, read only by sync_b
  logic [SYNC_W-1:0] sync_b; // Second stage
  logic [SYNC_W-1:0] sync_prev; // Previous second stage

  // Two flops for every outside input except arst_n, then a history stage
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sync_a <= '0;
      sync_b <= '0;
      sync_prev <= '0;
    end else begin
      sync_a <= {rise_toggle, scl, sda_in, channel_enable_pin,
                 fb_in_window, fb_out_window, overtemp_hot,
                 overtemp_cool, overcurrent_hiccup,
                 overtemp_warning_flag, switch_tick};
      sync_b <= sync_a;
      sync_prev <= sync_b;
    end
  end

  // Named views of the synchronised inputs
  logic scl_s, sda_s, scl_p, sda_p;
  logic [2:0] pin_en, in_win, out_win, oc_s;
  logic hot_s, cool_s, warn_s;
  logic rise_evt, fall_evt, start_evt, stop_evt, tick_evt;
  assign scl_s = sync_b[17];
  assign sda_s = sync_b[16];
  assign scl_p = sync_prev[17];
  assign sda_p = sync_prev[16];
  assign pin_en = sync_b[15:13];
  assign in_win = sync_b[12:10];
  assign out_win = sync_b[9:7];
  assign hot_s = sync_b[6];
  assign cool_s = sync_b[5];
  assign oc_s = sync_b[4:2];
  assign warn_s = sync_b[1];
  // Toggle change marks a captured bit; rx_bit is stable then
  assign rise_evt = sync_b[18] ^ sync_prev[18];
  assign fall_evt = scl_p & ~scl_s;
  // Start and stop: SDA moving while SCL is high
  assign start_evt = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_evt = scl_s & scl_p & ~sda_p & sda_s;
  assign tick_evt = sync_b[0] & ~sync_prev[0];

  // ****************************************
  // Status group: power-ok and thermal
  // ****************************************
  logic [2:0] power_ok;
  logic otp;
  logic restart;
  logic [2:0] run;
  logic [2:0] next_power_ok;
  logic next_otp;
  logic next_restart;
  logic [2:0] next_run;
  logic [7:0] health; // Live status byte
  logic [7:0] sel [3]; // Voltage select registers
  logic [7:0] cmd [3]; // Command registers

  // Hysteresis latches and run gating
  always_comb begin
    next_power_ok = power_ok;
    for (int i = 0; i < 3; i++) begin
      if (in_win[i]) begin
        next_power_ok[i] = 1'b1;
      end else if (out_win[i]) begin
        next_power_ok[i] = 1'b0;
      end
    end
    next_otp = otp;
    if (hot_s) begin
      next_otp = 1'b1;
    end else if (cool_s) begin
      next_otp = 1'b0;
    end
    // Restart pulse as the halt releases
    next_restart = otp & ~hot_s & cool_s;
    for (int i = 0; i < 3; i++) begin
      next_run[i] = pin_en[i] & ~cmd[i][DISABLE_BIT] & ~next_otp;
    end
  end

  // Status registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      power_ok <= 3'h0;
      otp <= 1'b0;
      restart <= 1'b0;
      run <= 3'h0;
    end else begin
      power_ok <= next_power_ok;
      otp <= next_otp;
      restart <= next_restart;
      run <= next_run;
    end
  end

  always_comb begin
    health = 8'h00;
    health[OVERTEMP_BIT] = otp;
    health[OVERCURRENT_LSB +: 3] = oc_s;
    health[WARNING_BIT] = warn_s;
    health[POWER_OK_LSB +: 3] = power_ok;
  end

  // ****************************************
  // Protocol and register file group
  // ****************************************
  phase_type phase;
  logic [3:0] cnt; // SCL pulses in this byte
  logic [7:0] shift; // Received byte
  logic [7:0] ptr; // Register pointer
  logic [7:0] tx; // Byte being sent
  logic oe; // Pull SDA low
  phase_type next_phase;
  logic [3:0] next_cnt;
  logic [7:0] next_shift;
  logic [7:0] next_ptr;
  logic [7:0] next_tx;
  logic next_oe;
  logic [7:0] next_sel [3];
  logic [7:0] next_cmd [3];
  logic hw_shutdown; // All enable pins low

  assign hw_shutdown = (pin_en == 3'h0);

  // Register read decode
  function automatic logic [7:0] read_reg(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      BUCK1_VOLTAGE_SELECT_OFS: v = sel[0];
      BUCK2_VOLTAGE_SELECT_OFS: v = sel[1];
      BUCK3_VOLTAGE_SELECT_OFS: v = sel[2];
      BUCK1_COMMAND_OFS: v = cmd[0];
      BUCK2_COMMAND_OFS: v = cmd[1];
      BUCK3_COMMAND_OFS: v = cmd[2];
      SYSTEM_HEALTH_OFS: v = health;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // Byte engine: start, stop, bits, acknowledge, commit
  always_comb begin
    next_phase = phase;
    next_cnt = cnt;
    next_shift = shift;
    next_ptr = ptr;
    next_tx = tx;
    next_oe = oe;
    next_sel = sel;
    next_cmd = cmd;
    if (start_evt) begin
      next_phase = PH_ADDR;
      next_cnt = 4'h0;
      next_oe = 1'b0;
    end else if (stop_evt) begin
      next_phase = PH_IDLE;
      next_cnt = 4'h0;
      next_oe = 1'b0;
    end else if (phase != PH_IDLE) begin
      if (rise_evt && cnt < ACK_PULSE) begin
        next_cnt = cnt + 4'h1;
        if (cnt < DATA_PULSES) begin
          next_shift = {shift[6:0], rx_bit};
        end else if (phase == PH_READ && rx_bit) begin
          // Master declined more data
          next_phase = PH_IDLE;
        end
      end
      if (fall_evt) begin
        case (cnt)
          DATA_PULSES: begin
            // Hold SDA low through ack pulse
            next_oe = 1'b1;
            case (phase)
              PH_ADDR: begin
                if (shift[7:1] != SLAVE_ADDR) begin
                  next_phase = PH_IDLE;
                  next_oe = 1'b0;
                end
              end
              PH_REG: begin
                next_ptr = shift;
              end
              PH_WRITE: begin
                if (!hw_shutdown) begin
                  for (int i = 0; i < 3; i++) begin
                    if (ptr == BUCK1_VOLTAGE_SELECT_OFS + 8'(i)) begin
                      next_sel[i] = shift;
                    end
                    if (ptr == BUCK1_COMMAND_OFS + 8'(i)) begin
                      next_cmd[i] = shift;
                    end
                  end
                end
              end
              PH_READ: begin
                // Release for the master's ack
                next_oe = 1'b0;
              end
              default: begin
                next_oe = 1'b0;
              end
            endcase
          end
          ACK_PULSE: begin
            next_cnt = 4'h0;
            next_oe = 1'b0;
            case (phase)
              PH_ADDR: begin
                if (shift[0]) begin
                  next_phase = PH_READ;
                  next_tx = read_reg(ptr);
                  next_oe = ~next_tx[7];
                end else begin
                  next_phase = PH_REG;
                end
              end
              PH_REG: begin
                next_phase = PH_WRITE;
              end
              PH_WRITE: begin
                next_ptr = ptr + 8'h1;
              end
              PH_READ: begin
                next_ptr = ptr + 8'h1;
                next_tx = read_reg(ptr + 8'h1);
                next_oe = ~next_tx[7];
              end
              default: begin
                next_phase = PH_IDLE;
              end
            endcase
          end
          default: begin
            // Next data bit onto SDA, MSB first
            if (phase == PH_READ && cnt != 4'h0) begin
              next_tx = {tx[6:0], 1'b0};
              next_oe = ~tx[6];
            end
          end
        endcase
      end
    end
  end

  // Protocol and register storage
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      phase <= PH_IDLE;
      cnt <= 4'h0;
      shift <= 8'h00;
      ptr <= 8'h00;
      tx <= 8'h00;
      oe <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        sel[i] <= SELECT_RESET;
        cmd[i] <= COMMAND_RESET;
      end
    end else begin
      phase <= next_phase;
      cnt <= next_cnt;
      shift <= next_shift;
      ptr <= next_ptr;
      tx <= next_tx;
      oe <= next_oe;
      sel <= next_sel;
      cmd <= next_cmd;
    end
  end

  // ****************************************
  // Per-channel voltage ramp
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gen_ramp
      logic [6:0] code; // Code now applied
      logic [6:0] ticks; // Switch ticks since last step
      logic [10:0] mv;
      logic [6:0] next_code;
      logic [6:0] next_ticks;
      logic [10:0] next_mv;
      logic [6:0] span;

      // 2^N switch ticks per step
      assign span = 7'((8'h1 << cmd[g][SLEW_LSB +: 3]) - 8'h1);

      // Step toward the target once every span+1 ticks
      always_comb begin
        next_code = code;
        next_ticks = ticks;
        // Follow code only with go set
        if (tick_evt && sel[g][GO_BIT]) begin
          if (ticks >= span) begin
            next_ticks = 7'h0;
            if (code < sel[g][6:0]) begin
              next_code = code + 7'h1;
            end else if (code > sel[g][6:0]) begin
              next_code = code - 7'h1;
            end
          end else begin
            next_ticks = ticks + 7'h1;
          end
        end
        // 10 mV per code above base
        next_mv = VID_BASE_MV + 11'(next_code) * 11'(VID_STEP_MV);
      end

      // Ramp registers
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          code <= 7'h0;
          ticks <= 7'h0;
          mv <= VID_BASE_MV;
        end else begin
          code <= next_code;
          ticks <= next_ticks;
          mv <= next_mv;
        end
      end

      assign applied_code[g*7 +: 7] = code;
      assign target_mv[g*11 +: 11] = mv;
      assign vid_go[g] = sel[g][GO_BIT];
      assign forced_pwm[g] = cmd[g][FORCED_PWM_BIT];
    end
  endgenerate

  // ****************************************
  // Outputs
  // ****************************************
  assign sda_out = 1'b0;
  assign sda_oe = oe;
  assign channel_power_ok = power_ok;
  assign switching_halt = otp;
  assign sequence_restart = restart;
  assign channel_run = run;
endmodule

// [dv/buck_regs_sva.sv]
`timescale 1ns/1ps
// ****************************************
// Port checker for the control register bank
// ****************************************
module buck_regs_sva (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [2:0] channel_enable_pin,
  input wire logic [2:0] fb_in_window,
  input wire logic [2:0] fb_out_window,
  input wire logic overtemp_hot,
  input wire logic [2:0] channel_power_ok,
  input wire logic switching_halt,
  input wire logic sequence_restart,
  input wire logic [2:0] channel_run,
  input wire logic [20:0] applied_code,
  input wire logic [32:0] target_mv
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  chk_pok_set: assert property (
    fb_in_window[0] [*5] |-> channel_power_ok[0]
  ) else $error("power ok did not set");
  chk_pok_clear: assert property (
    (fb_out_window[0] && !fb_in_window[0]) [*5] |-> !channel_power_ok[0]
  ) else $error("power ok did not clear");
  chk_pok_hold: assert property (
    !fb_out_window[0] [*4] ##0 channel_power_ok[0] |=> channel_power_ok[0]
  ) else $error("power ok dropped inside hysteresis");
  chk_halt_hot: assert property (
    overtemp_hot [*5] |-> switching_halt
  ) else $error("hot die did not halt switching");
  chk_halt_stops_run: assert property (
    switching_halt [*2] |-> channel_run == 3'h0
  ) else $error("channel runs during halt");
  chk_restart_pulse: assert property (
    sequence_restart |=> !sequence_restart && !switching_halt
  ) else $error("restart pulse malformed");
  chk_pin_stops_run: assert property (
    !channel_enable_pin[0] [*5] |-> !channel_run[0]
  ) else $error("channel runs with pin low");
  chk_target_map: assert property (
    $stable(applied_code[6:0]) |->
      target_mv[10:0] == 11'd680 + 11'd10 * {4'h0, applied_code[6:0]}
  ) else $error("target voltage does not match code");
  chk_step_single: assert property (
    $changed(applied_code[6:0]) |->
      applied_code[6:0] == $past(applied_code[6:0]) + 7'h01 ||
      applied_code[6:0] == $past(applied_code[6:0]) - 7'h01
  ) else $error("code moved more than one step");
endmodule
bind triple_buck_i2c_control_regs buck_regs_sva u_sva (.clock, .arst_n,
  .channel_enable_pin, .fb_in_window, .fb_out_window, .overtemp_hot,
  .channel_power_ok, .switching_halt, .sequence_restart, .channel_run,
  .applied_code, .target_mv);

// [dv/i2c_master_model.sv]
`timescale 1ns/1ps
// ****************************************
// Bus master: SCL stands high outside frames
// ****************************************
module i2c_master_model (
  output logic scl,
  output logic sda_pull,
  input wire logic sda_line
);
  localparam int HALF = 15;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // Start or repeated start, ends with SCL low
  task automatic start_cond;
    sda_pull = 1'b0;
    #HALF scl = 1'b1;
    #HALF sda_pull = 1'b1;
    #HALF scl = 1'b0;
  endtask
  // Stop, line released to the pull-up
  task automatic stop_cond;
    #5 sda_pull = 1'b1;
    #HALF scl = 1'b1;
    #HALF sda_pull = 1'b0;
    #HALF;
  endtask
  // One SCL pulse; data changes only while SCL is low
  task automatic pulse(input logic pull, output logic seen);
    #5 sda_pull = pull;
    #(HALF - 5) scl = 1'b1;
    #(HALF - 1) seen = sda_line;
    #1 scl = 1'b0;
  endtask
  // Byte out MSB first, then the slave's acknowledge
  task automatic put_byte(input logic [7:0] b, output logic acked);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      pulse(~b[i], s);
    end
    pulse(1'b0, s);
    acked = ~s;
  endtask
  // Byte in, master acks unless last
  task automatic get_byte(input logic last, output logic [7:0] b);
    logic s; // Line level during the master's own ack pulse
    for (int i = 7; i >= 0; i--) begin
      pulse(1'b0, b[i]);
    end
    // Ack or nack pulse; its sample must not touch the byte
    pulse(~last, s);
  endtask
endmodule

// [dv/triple_buck_i2c_control_regs_tb.sv]
`timescale 1ns/1ps
module triple_buck_i2c_control_regs_tb;
  import buck_regs_pkg::*;
  localparam logic [6:0] ADDR = 7'h48;
  logic clock, arst_n, scl, sda_pull, sda_line, sda_out, sda_oe, ack;
  logic hot, cool, warn, tick, halt, restart, seen;
  logic [2:0] enable_pin, in_win, out_win, hiccup, pok, run, fpwm, go;
  logic [20:0] code;
  logic [32:0] mv;
  logic [7:0] rd;
  logic [7:0] pats [6] = '{8'h85, 8'h83, 8'h7f, 8'h02, 8'h12, 8'h71};
  logic [6:0] bad_addr [3] = '{7'h49, 7'h00, 7'h78};
  int fails, n_compared, cycles;
  // Open-drain wire with pull-up
  assign sda_line = (sda_pull || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
  triple_buck_i2c_control_regs u_dut (.clock(clock), .arst_n(arst_n),
    .scl(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .channel_enable_pin(enable_pin), .fb_in_window(in_win),
    .fb_out_window(out_win), .overtemp_hot(hot), .overtemp_cool(cool),
    .overcurrent_hiccup(hiccup), .overtemp_warning_flag(warn),
    .switch_tick(tick), .channel_power_ok(pok), .switching_halt(halt),
    .sequence_restart(restart), .channel_run(run), .forced_pwm(fpwm),
    .vid_go(go), .applied_code(code), .target_mv(mv));
  i2c_master_model u_master (.scl(scl), .sda_pull(sda_pull),
    .sda_line(sda_line));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // Cut a hang short
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      $display("BAD %0t run too long", $time);
      give_verdict();
    end
  end
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t saw %h wanted %h", $time, got, exp);
    end
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic open_reg(input logic [7:0] ofs);
    u_master.start_cond();
    u_master.put_byte({ADDR, 1'b0}, ack);
    check(ack, 1'b1);
    u_master.put_byte(ofs, ack);
    check(ack, 1'b1);
  endtask
  task automatic write_reg(input logic [7:0] ofs, input logic [7:0] d);
    open_reg(ofs);
    u_master.put_byte(d, ack);
    check(ack, 1'b1);
    u_master.stop_cond();
  endtask
  task automatic read_reg(input logic [7:0] ofs, output logic [7:0] d);
    open_reg(ofs);
    u_master.start_cond();
    u_master.put_byte({ADDR, 1'b1}, ack);
    check(ack, 1'b1);
    u_master.get_byte(1'b1, d);
    u_master.stop_cond();
  endtask
  initial begin
    {arst_n, hot, warn, tick, in_win, out_win, hiccup} = '0;
    cool = 1'b1;
    enable_pin = 3'h7;
    wait_clk(5);
    arst_n = 1'b1;
    wait_clk(3);
    for (int i = 0; i < 6; i++) begin
      read_reg(i[7:0], rd);
      check(rd, 8'h00);
    end
    $display("reset values done");
    for (int i = 0; i < 6; i++) write_reg(i[7:0], pats[i]);
    for (int i = 0; i < 6; i++) begin
      read_reg(i[7:0], rd);
      check(rd, pats[i]);
    end
    check(go, 3'b011);
    check({fpwm, run}, 6'b011011);
    repeat (8) begin
      tick = 1'b1;
      wait_clk(4);
      tick = 1'b0;
      wait_clk(4);
    end
    check(code, {7'h00, 7'h03, 7'h05});
    check(mv, {11'd680, 11'd710, 11'd730});
    $display("register and ramp done");
    in_win = 3'b101;
    hiccup = 3'b010;
    warn = 1'b1;
    wait_clk(6);
    check(pok, 3'b101);
    in_win = 3'b000;
    wait_clk(6);
    check(pok, 3'b101);
    read_reg(SYSTEM_HEALTH_OFS, rd);
    check(rd, 8'h2d);
    write_reg(SYSTEM_HEALTH_OFS, 8'hff);
    read_reg(SYSTEM_HEALTH_OFS, rd);
    check(rd, 8'h2d);
    wait_clk(1);
    out_win = 3'b001;
    wait_clk(6);
    check(pok, 3'b100);
    read_reg(SYSTEM_HEALTH_OFS, rd);
    check(rd, 8'h2c);
    $display("status done");
    for (int i = 0; i < 3; i++) begin
      u_master.start_cond();
      u_master.put_byte({bad_addr[i], 1'b0}, ack);
      u_master.stop_cond();
      check(ack, 1'b0);
    end
    wait_clk(1);
    enable_pin = 3'h0;
    wait_clk(6);
    check(run, 3'b000);
    write_reg(BUCK1_VOLTAGE_SELECT_OFS, 8'h11);
    wait_clk(1);
    enable_pin = 3'h7;
    wait_clk(6);
    read_reg(BUCK1_VOLTAGE_SELECT_OFS, rd);
    check(rd, 8'h85);
    $display("address and shutdown done");
    wait_clk(1);
    hot = 1'b1;
    cool = 1'b0;
    wait_clk(8);
    check({halt, run}, 4'b1000);
    read_reg(SYSTEM_HEALTH_OFS, rd);
    check(rd, 8'hac);
    wait_clk(1);
    hot = 1'b0;
    wait_clk(8);
    check(halt, 1'b1);
    cool = 1'b1;
    seen = 1'b0;
    repeat (10) begin
      wait_clk(1);
      seen = seen | restart;
    end
    check({seen, halt}, 2'b10);
    $display("thermal done");
    write_reg(BUCK1_COMMAND_OFS, 8'h03);
    write_reg(BUCK2_COMMAND_OFS, 8'h13);
    wait_clk(6);
    check(run, 3'b000);
    read_reg(BUCK2_COMMAND_OFS, rd);
    check(rd, 8'h13);
    $display("software shutdown done");
    give_verdict();
  end
endmodule
